//--- ptct_top.sv
// Paper tape code translator with reader operator state and host character buffer.
// Assumes panel buttons are one-cycle pulses and switches are steady levels.
`timescale 1ns/10ps
`default_nettype none
module ptct_top #(
	parameter int MAP_DEPTH = ptct_pkg::MAP_DEPTH,
	parameter int STOP_NUM = ptct_pkg::STOP_NUM,
	parameter int FIFO_DEPTH = ptct_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Reader frames
	input wire logic frame_valid,
	input wire ptct_pkg::ptct_frame_t frame,
	output logic frame_ready,
	// Tape sense
	input wire logic tape_bot,
	input wire logic tape_eot,
	// Panel buttons
	input wire logic pb_local,
	input wire logic pb_remote,
	input wire logic pb_rewind,
	input wire logic pb_back,
	input wire logic pb_fwd,
	input wire logic pb_stop,
	// Panel switches
	input wire logic reel_mode,
	input wire logic parity_on,
	input wire logic shift_en,
	input wire logic xlat_en,
	input wire logic binary_mode,
	// Plugboard wiring
	input wire logic [ptct_pkg::FRAME_W-1:0] shift_code,
	input wire logic [ptct_pkg::FRAME_W-1:0] unshift_code,
	input wire ptct_pkg::ptct_or_cfg_t or_cfg [ptct_pkg::OR_NUM],
	input wire ptct_pkg::ptct_map_cfg_t map_cfg [MAP_DEPTH],
	input wire ptct_pkg::ptct_stop_cfg_t stop_cfg [STOP_NUM],
	// Host side
	input wire logic host_start,
	input wire logic host_ready,
	output logic [ptct_pkg::CHAR_W-1:0] six_bit_char_code,
	output logic host_valid,
	output logic host_err,
	output logic host_eor,
	// Motion and lamps
	output logic tape_fwd,
	output logic tape_rev,
	output logic local_ind,
	output logic remote_ind,
	output logic parity_ind
);
	localparam int FW = ptct_pkg::FRAME_W;
	localparam int CHW = ptct_pkg::CHAR_W;

	ptct_pkg::ptct_state_t state_reg;
	ptct_pkg::ptct_state_t state_next;
	logic case_reg;
	logic case_next;
	logic parity_ind_reg;
	logic parity_ind_next;
	logic tape_fwd_reg;
	logic tape_rev_reg;
	logic local_ind_reg;
	logic remote_ind_reg;
	logic [CHW-1:0] host_char_reg;
	logic host_valid_reg;
	logic host_err_reg;
	logic host_eor_reg;
	logic eor_pend_reg;

	logic reading;
	logic frame_take;
	logic [FW-1:0] raw_code;
	logic [FW-1:0] eff_code;
	logic is_shift;
	logic is_unshift;
	logic case_code;
	logic map_hit;
	logic [CHW-1:0] map_char;
	logic stop_hit;
	logic stop_store;
	logic [CHW-1:0] stop_char;
	logic ctl_hit;
	logic tr_has;
	logic halt_off;
	ptct_pkg::ptct_word_t push_word;
	ptct_pkg::ptct_word_t pop_word;
	logic fifo_push;
	logic fifo_out_valid;
	logic pop;

	// A frame is taken once per strobe, only while tape moves
	assign reading = (state_reg == ptct_pkg::ST_READ) || (state_reg == ptct_pkg::ST_FWD)
		|| (state_reg == ptct_pkg::ST_BACK);
	assign frame_take = frame_valid & frame_ready & reading;

	// Case tracking; with translation on a case code is consumed, not sent
	assign raw_code = frame.code;
	assign is_shift = shift_en & (raw_code == shift_code);
	assign is_unshift = shift_en & (raw_code == unshift_code) & ~is_shift;
	assign case_code = is_shift | is_unshift;
	assign eff_code = shift_en ? {case_reg, raw_code[ptct_pkg::CASE_BIT-1:0]} : raw_code;
	assign case_next = (frame_take & is_shift) ? 1'b1 : ((frame_take & is_unshift) ? 1'b0 : case_reg);

	// Plugboard lookup on the indexed code
	ptct_xlate #(
		.MAP_DEPTH(MAP_DEPTH),
		.STOP_NUM(STOP_NUM)
	) u_xlate (
		.code(eff_code),
		.or_cfg(or_cfg),
		.map_cfg(map_cfg),
		.stop_cfg(stop_cfg),
		.map_hit(map_hit),
		.map_char(map_char),
		.stop_hit(stop_hit),
		.stop_store(stop_store),
		.stop_char(stop_char)
	);

	// Stop detectors only exist on the translated path
	assign ctl_hit = xlat_en & stop_hit;
	assign tr_has = ctl_hit ? stop_store : (binary_mode | map_hit);
	assign push_word.chr = !xlat_en ? raw_code[CHW-1:0]
		: (binary_mode ? eff_code[CHW-1:0] : (ctl_hit ? stop_char : map_char));
	assign push_word.has_char = ~xlat_en | (~case_code & tr_has);
	assign push_word.err = parity_on & frame.parity_err;
	assign push_word.eor = ctl_hit;

	// Only host reading fills the buffer; local motion never reaches it
	assign fifo_push = frame_take & (state_reg == ptct_pkg::ST_READ)
		& (push_word.has_char | push_word.eor);
	assign halt_off = frame_take & (ctl_hit | push_word.err);

	// Operator state; buttons outside their state are ignored
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ptct_pkg::ST_LOCAL: begin
				if (pb_remote) begin
					state_next = ptct_pkg::ST_REMOTE;
				end else if (pb_rewind & reel_mode) begin
					state_next = ptct_pkg::ST_REWIND;
				end else if (pb_back) begin
					state_next = ptct_pkg::ST_BACK;
				end else if (pb_fwd) begin
					state_next = ptct_pkg::ST_FWD;
				end
			end
			ptct_pkg::ST_REWIND: begin
				if (pb_stop | tape_bot) begin
					state_next = ptct_pkg::ST_LOCAL;
				end
			end
			ptct_pkg::ST_BACK: begin
				if (pb_stop | tape_bot | halt_off) begin
					state_next = ptct_pkg::ST_LOCAL;
				end
			end
			ptct_pkg::ST_FWD: begin
				if (pb_stop | tape_eot | halt_off) begin
					state_next = ptct_pkg::ST_LOCAL;
				end
			end
			ptct_pkg::ST_REMOTE: begin
				if (pb_local) begin
					state_next = ptct_pkg::ST_LOCAL;
				end else if (host_start) begin
					state_next = ptct_pkg::ST_READ;
				end
			end
			ptct_pkg::ST_READ: begin
				if (pb_local) begin
					state_next = ptct_pkg::ST_LOCAL;
				end else if (tape_eot | (frame_take & ctl_hit)) begin
					state_next = ptct_pkg::ST_REMOTE;
				end
			end
			default: state_next = ptct_pkg::ST_LOCAL; // Unused codes fall back to the safe local state
		endcase
	end

	// Parity lamp: only sets while checking is on, so the clear never races a set
	assign parity_ind_next = parity_on & (parity_ind_reg | (frame_take & frame.parity_err));

	// Character buffer; host back-pressure stalls the reader through frame_ready
	ptct_fifo #(
		.WIDTH(ptct_pkg::WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rstn(rstn),
		.in_valid(fifo_push),
		.in_data(push_word),
		.in_ready(frame_ready),
		.out_valid(fifo_out_valid),
		.out_data(pop_word),
		.out_ready(pop)
	);

	// End of record holds the drain for one cycle so it trails its character
	assign pop = fifo_out_valid & host_ready & ~eor_pend_reg;

	// Operator state and lamps follow the next state so they move together
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state_reg <= ptct_pkg::ST_LOCAL;
			case_reg <= ptct_pkg::CASE_RST;
			parity_ind_reg <= 1'b0;
			tape_fwd_reg <= 1'b0;
			tape_rev_reg <= 1'b0;
			local_ind_reg <= 1'b1;
			remote_ind_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			case_reg <= case_next;
			parity_ind_reg <= parity_ind_next;
			tape_fwd_reg <= (state_next == ptct_pkg::ST_FWD) || (state_next == ptct_pkg::ST_READ);
			tape_rev_reg <= (state_next == ptct_pkg::ST_REWIND) || (state_next == ptct_pkg::ST_BACK);
			local_ind_reg <= (state_next != ptct_pkg::ST_REMOTE) && (state_next != ptct_pkg::ST_READ);
			remote_ind_reg <= (state_next == ptct_pkg::ST_REMOTE) || (state_next == ptct_pkg::ST_READ);
		end
	end

	// Host outputs; valid and error are one-cycle pulses per drained word
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			host_char_reg <= ptct_pkg::CHAR_RST;
			host_valid_reg <= 1'b0;
			host_err_reg <= 1'b0;
			host_eor_reg <= 1'b0;
			eor_pend_reg <= 1'b0;
		end else begin
			host_char_reg <= pop ? pop_word.chr : host_char_reg;
			host_valid_reg <= pop & pop_word.has_char;
			host_err_reg <= pop & pop_word.err;
			host_eor_reg <= eor_pend_reg;
			eor_pend_reg <= pop & pop_word.eor;
		end
	end

	assign six_bit_char_code = host_char_reg;
	assign host_valid = host_valid_reg;
	assign host_err = host_err_reg;
	assign host_eor = host_eor_reg;
	assign tape_fwd = tape_fwd_reg;
	assign tape_rev = tape_rev_reg;
	assign local_ind = local_ind_reg;
	assign remote_ind = remote_ind_reg;
	assign parity_ind = parity_ind_reg;

	// Checks on the operator sequence and the host stream
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence shift_seen_s;
		frame_take && is_shift;
	endsequence
	sequence next_plain_s;
		frame_take && shift_en && !is_unshift;
	endsequence
	sequence pop_eor_s;
		pop && pop_word.eor;
	endsequence

	local_select_a: assert property ((state_reg == ptct_pkg::ST_READ) && pb_local
		|=> local_ind_reg && !remote_ind_reg && !tape_fwd_reg) else $error("local not taken");
	remote_select_a: assert property ((state_reg == ptct_pkg::ST_LOCAL) && pb_remote
		|=> remote_ind_reg && !local_ind_reg) else $error("remote not taken");
	rewind_gate_a: assert property ((state_reg == ptct_pkg::ST_LOCAL) && pb_rewind && !reel_mode
		|=> !tape_rev_reg) else $error("rewind ran in strip mode");
	rewind_end_a: assert property ((state_reg == ptct_pkg::ST_REWIND) && tape_bot
		|=> !tape_rev_reg ##1 !tape_rev_reg) else $error("rewind passed tape start");
	back_end_a: assert property ((state_reg == ptct_pkg::ST_BACK) && frame_take && ctl_hit
		|=> !tape_rev_reg && local_ind_reg) else $error("backspace missed control code");
	fwd_parity_a: assert property ((state_reg == ptct_pkg::ST_FWD) && frame_take && push_word.err
		|=> !tape_fwd_reg) else $error("offline parity did not stop");
	stop_local_a: assert property (((state_reg == ptct_pkg::ST_FWD) || (state_reg == ptct_pkg::ST_BACK))
		&& pb_stop |=> !tape_fwd_reg && !tape_rev_reg && local_ind_reg) else $error("panel stop ignored in local");
	stop_ignore_a: assert property ((state_reg == ptct_pkg::ST_READ) && pb_stop && !pb_local
		&& !tape_eot && !(frame_take && ctl_hit) |=> tape_fwd_reg) else $error("panel stop acted in remote");
	parity_set_a: assert property (frame_take && frame.parity_err && parity_on
		|=> parity_ind_reg) else $error("parity lamp not set");
	parity_clear_a: assert property (!parity_on |=> !parity_ind_reg) else $error("parity lamp not cleared");
	online_parity_a: assert property ((state_reg == ptct_pkg::ST_READ) && frame_take && push_word.err
		&& !ctl_hit && !pb_local && !tape_eot |=> tape_fwd_reg && (state_reg == ptct_pkg::ST_READ))
		else $error("online parity halted reading");
	stop_halt_a: assert property ((state_reg == ptct_pkg::ST_READ) && frame_take && ctl_hit && !pb_local
		|=> !tape_fwd_reg && remote_ind_reg) else $error("stop code did not halt");
	case_force_a: assert property (shift_seen_s ##1 next_plain_s |-> eff_code[ptct_pkg::CASE_BIT])
		else $error("shift case not forced");
	eor_order_a: assert property (pop_eor_s |=> !host_eor_reg ##1 host_eor_reg && !host_valid_reg)
		else $error("end of record out of order");
endmodule
`default_nettype wire

//--- ptct_pkg.sv
// Shared constants, field layouts and carrier types for the paper tape code translator.
// Assumes one reader frame strobe per tape frame and a host that drains six-bit characters.
package ptct_pkg;
	// Frame and character geometry
	localparam int FRAME_W = 8;
	localparam int CHAR_W = 6;
	localparam int COL_LSB = 0;
	localparam int ROW_LSB = 4;
	localparam int CASE_BIT = 7;
	localparam int ZONE_LSB = 4;
	// Plugboard resources
	localparam int MAP_DEPTH = 64;
	localparam int STOP_NUM = 8;
	localparam int OR_NUM = 6;
	localparam int OR_IN = 3;
	// Output buffer depth
	localparam int FIFO_DEPTH = 8;
	// Reset values
	localparam logic [CHAR_W-1:0] CHAR_RST = 6'h00;
	localparam logic CASE_RST = 1'b0;

	// One frame from the reader head
	typedef struct packed {
		logic [FRAME_W-1:0] code;
		logic parity_err;
	} ptct_frame_t;

	// One three-input OR merge element
	typedef struct packed {
		logic [OR_IN-1:0] en;
		logic [OR_IN-1:0][FRAME_W-1:0] code;
	} ptct_or_cfg_t;

	// One entry of the translation table
	typedef struct packed {
		logic en;
		logic [FRAME_W-1:0] code;
		logic [OR_NUM-1:0] or_sel;
		logic [CHAR_W-1:0] chr;
	} ptct_map_cfg_t;

	// One stop detector
	typedef struct packed {
		logic en;
		logic [FRAME_W-1:0] code;
		logic [OR_NUM-1:0] or_sel;
		logic store;
		logic [CHAR_W-1:0] chr;
	} ptct_stop_cfg_t;

	// Word carried to the host through the buffer
	typedef struct packed {
		logic [CHAR_W-1:0] chr;
		logic has_char;
		logic err;
		logic eor;
	} ptct_word_t;

	localparam int WORD_W = $bits(ptct_word_t);

	// Operator and reading states
	typedef enum logic [2:0] {
		ST_LOCAL,
		ST_REWIND,
		ST_BACK,
		ST_FWD,
		ST_REMOTE,
		ST_READ
	} ptct_state_t;
endpackage

//--- ptct_fifo.sv
// Flop-based FIFO between the translator and the host side.
// Assumes the writer pushes only while in_ready is high.
`timescale 1ns/10ps
`default_nettype none
module ptct_fifo #(
	parameter int WIDTH = ptct_pkg::WORD_W,
	parameter int DEPTH = ptct_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;
	logic in_ready_reg;
	logic push;
	logic pop;

	// Handshakes; ready is registered so the writer sees a clean flop
	assign push = in_valid & in_ready_reg;
	assign pop = out_valid & out_ready;
	assign count_next = count_reg + CW'(push) - CW'(pop);
	assign in_ready = in_ready_reg;
	assign out_valid = (count_reg != '0);
	assign out_data = mem_reg[rd_ptr_reg];

	// Storage is not reset; only pointers, count and ready carry control state
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	// Pointers wrap explicitly so any depth works
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			in_ready_reg <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + PW'(1);
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + PW'(1);
			end
			count_reg <= count_next;
			in_ready_reg <= (count_next < FULL);
		end
	end
endmodule
`default_nettype wire

//--- ptct_xlate.sv
// Combinational plugboard lookup: OR merges, translation table and stop detectors.
// Assumes the configuration is static while frames are read.
`timescale 1ns/10ps
`default_nettype none
module ptct_xlate #(
	parameter int MAP_DEPTH = ptct_pkg::MAP_DEPTH,
	parameter int STOP_NUM = ptct_pkg::STOP_NUM
) (
	// Indexed frame code
	input wire logic [ptct_pkg::FRAME_W-1:0] code,
	// Plugboard wiring
	input wire ptct_pkg::ptct_or_cfg_t or_cfg [ptct_pkg::OR_NUM],
	input wire ptct_pkg::ptct_map_cfg_t map_cfg [MAP_DEPTH],
	input wire ptct_pkg::ptct_stop_cfg_t stop_cfg [STOP_NUM],
	// Lookup result
	output logic map_hit,
	output logic [ptct_pkg::CHAR_W-1:0] map_char,
	output logic stop_hit,
	output logic stop_store,
	output logic [ptct_pkg::CHAR_W-1:0] stop_char
);
	// One direct code plus any selected OR merges feed a target
	function automatic logic src_hit(
		input logic [ptct_pkg::FRAME_W-1:0] c,
		input logic en,
		input logic [ptct_pkg::FRAME_W-1:0] want,
		input logic [ptct_pkg::OR_NUM-1:0] sel,
		input logic [ptct_pkg::OR_NUM-1:0] orh
	);
		return (en && (c == want)) || (|(sel & orh));
	endfunction

	logic [ptct_pkg::OR_NUM-1:0] or_hit;

	// Each OR element matches any of its three wired codes
	always_comb begin
		or_hit = '0;
		for (int g = 0; g < ptct_pkg::OR_NUM; g++) begin
			for (int k = 0; k < ptct_pkg::OR_IN; k++) begin
				if (or_cfg[g].en[k] && (code == or_cfg[g].code[k])) begin
					or_hit[g] = 1'b1;
				end
			end
		end
	end

	// Lowest entry wins when wiring overlaps; the scan runs downward
	always_comb begin
		map_hit = 1'b0;
		map_char = ptct_pkg::CHAR_RST;
		for (int i = MAP_DEPTH - 1; i >= 0; i--) begin
			if (src_hit(code, map_cfg[i].en, map_cfg[i].code, map_cfg[i].or_sel, or_hit)) begin
				map_hit = 1'b1;
				map_char = map_cfg[i].chr;
			end
		end
	end

	// Stop detectors, lowest index wins
	always_comb begin
		stop_hit = 1'b0;
		stop_store = 1'b0;
		stop_char = ptct_pkg::CHAR_RST;
		for (int j = STOP_NUM - 1; j >= 0; j--) begin
			if (src_hit(code, stop_cfg[j].en, stop_cfg[j].code, stop_cfg[j].or_sel, or_hit)) begin
				stop_hit = 1'b1;
				stop_store = stop_cfg[j].store;
				stop_char = stop_cfg[j].chr;
			end
		end
	end
endmodule
`default_nettype wire

//--- ptct_host_model.sv
// Host side model: the I/O control unit that drains six-bit characters.
// Assumes the bench watches the delivered words; this model only paces acceptance.
`timescale 1ns/10ps
`default_nettype none
module ptct_host_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Pacing select from the bench
	input wire logic slow,
	// Acceptance towards the translator
	output logic host_ready
);
	int cnt;

	// Slow pacing opens one cycle in 32 so the buffer backs up and the reader must hold
	always @(negedge core_clk) begin
		if (rstn !== 1'b1) begin
			cnt <= 0;
			host_ready <= 1'b0;
		end else begin
			cnt <= cnt + 1;
			host_ready <= !slow || (cnt % 32 == 0);
		end
	end
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the paper tape code translator with a queue-based reference model.
// Assumes the plugboard wiring stays fixed for the whole run.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic core_clk, rstn, frame_valid, frame_ready, tape_bot, tape_eot, host_start, host_ready, slow;
	logic reel_mode, parity_on, shift_en, xlat_en, binary_mode, case_m, lamp_exp, saw_full;
	logic host_valid, host_err, host_eor, tape_fwd, tape_rev, local_ind, remote_ind, parity_ind;
	logic [5:0] pb;
	logic [5:0] chr;
	logic [7:0] shift_code, unshift_code, c;
	logic [31:0] rnd;
	logic [6:0] exp_q[$];
	logic [3:0] modes [5] = '{4'b1001, 4'b1010, 4'b1101, 4'b0000, 4'b1111};
	int err_count, checks_done, eor_got, eor_exp, n;
	ptct_pkg::ptct_frame_t frame_s;
	ptct_pkg::ptct_or_cfg_t or_cfg [ptct_pkg::OR_NUM];
	ptct_pkg::ptct_map_cfg_t map_cfg [ptct_pkg::MAP_DEPTH];
	ptct_pkg::ptct_stop_cfg_t stop_cfg [ptct_pkg::STOP_NUM];

	ptct_top ptct_top_inst (.core_clk(core_clk), .rstn(rstn), .frame_valid(frame_valid), .frame(frame_s),
		.frame_ready(frame_ready), .tape_bot(tape_bot), .tape_eot(tape_eot), .pb_local(pb[0]),
		.pb_remote(pb[1]), .pb_rewind(pb[2]), .pb_back(pb[3]), .pb_fwd(pb[4]), .pb_stop(pb[5]),
		.reel_mode(reel_mode), .parity_on(parity_on), .shift_en(shift_en), .xlat_en(xlat_en),
		.binary_mode(binary_mode), .shift_code(shift_code), .unshift_code(unshift_code), .or_cfg(or_cfg),
		.map_cfg(map_cfg), .stop_cfg(stop_cfg), .host_start(host_start), .host_ready(host_ready),
		.six_bit_char_code(chr), .host_valid(host_valid), .host_err(host_err), .host_eor(host_eor),
		.tape_fwd(tape_fwd), .tape_rev(tape_rev), .local_ind(local_ind), .remote_ind(remote_ind),
		.parity_ind(parity_ind));
	ptct_host_model ptct_host_model_inst (.core_clk(core_clk), .rstn(rstn), .slow(slow), .host_ready(host_ready));

	// Free-running 40 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic chk1(logic g, logic e);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk7(logic [6:0] g, logic [6:0] e);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// A target is hit directly or through any OR merge it selects
	function automatic logic hit(logic en, logic [7:0] code, logic [5:0] sel, logic [7:0] ix);
		logic h;
		h = en && code == ix;
		for (int e = 0; e < 6; e++)
			for (int k = 0; k < 3; k++)
				if (sel[e] && or_cfg[e].en[k] && or_cfg[e].code[k] == ix) h = 1'b1;
		return h;
	endfunction

	// Reference translation of one taken frame in the reading state
	task automatic model_frame(logic [7:0] fc, logic pe);
		logic [7:0] ix;
		int ch;
		int s;
		ch = -1;
		s = -1;
		if (pe && parity_on) lamp_exp = 1'b1;
		if (shift_en && (fc == shift_code || fc == unshift_code)) begin
			case_m = (fc == shift_code);
			if (xlat_en) return; // Bypass still sends case codes as plain characters
		end
		ix = shift_en ? {case_m, fc[6:0]} : fc;
		for (int i = 7; i >= 0; i--)
			if (hit(stop_cfg[i].en, stop_cfg[i].code, stop_cfg[i].or_sel, ix)) s = i;
		if (!xlat_en) ch = fc[5:0];
		else if (s >= 0) begin
			eor_exp++;
			if (stop_cfg[s].store) ch = binary_mode ? ix[5:0] : stop_cfg[s].chr;
		end else if (binary_mode) ch = ix[5:0];
		else for (int i = 63; i >= 0; i--)
			if (hit(map_cfg[i].en, map_cfg[i].code, map_cfg[i].or_sel, ix)) ch = map_cfg[i].chr;
		if (ch >= 0) exp_q.push_back({pe && parity_on, 6'(ch)});
	endtask

	task automatic press(int b);
		@(negedge core_clk);
		pb[b] = 1'b1;
		@(negedge core_clk);
		pb = 6'h00;
	endtask

	// Offer a frame and hold it until the reader side accepts it
	task automatic send_frame(logic [7:0] fc, logic pe);
		int k;
		@(negedge core_clk);
		frame_valid = 1'b1;
		frame_s = '{code: fc, parity_err: pe};
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (frame_ready !== 1'b1 && k < 2000);
		chk1(frame_ready, 1'b1);
	endtask

	// Released lines show the inverse, so stale data never looks valid
	task automatic idle_frame();
		@(negedge core_clk);
		frame_valid = 1'b0;
		frame_s.code = ~frame_s.code;
	endtask

	// Every delivered word must match the head of the expected queue
	always @(posedge core_clk) begin
		if (rstn === 1'b1) begin
			if (host_valid === 1'b1 || host_err === 1'b1) begin
				if (exp_q.size() == 0) chk7({host_err, chr}, ~{host_err, chr});
				else chk7({host_err, chr}, exp_q.pop_front());
			end
			if (host_eor === 1'b1) begin
				eor_got++;
				chk1(exp_q.size() == 0, 1'b1);
			end
			if (frame_valid === 1'b1 && frame_ready === 1'b0) saw_full = 1'b1;
		end
	end

	// Watchdog sized well above the longest expected run
	initial begin
		repeat (40000) @(posedge core_clk);
		err_count++;
		$display("Timeout at %0t", $time);
		tally_and_finish();
	end

	initial begin
		{rstn, frame_valid, tape_bot, tape_eot, host_start, slow, reel_mode, parity_on} = 8'h00;
		{shift_en, binary_mode, case_m, lamp_exp, saw_full} = 5'h00;
		xlat_en = 1'b1;
		pb = 6'h00;
		frame_s = '{code: 8'h00, parity_err: 1'b0};
		shift_code = 8'h5B;
		unshift_code = 8'h57;
		rnd = 32'h9fe2;
		foreach (map_cfg[i]) map_cfg[i] = '{en: i < 40, code: 8'(i * 3), or_sel: 6'h00, chr: 6'(i) ^ 6'h15};
		map_cfg[40].or_sel = 6'h07;
		map_cfg[40].chr = 6'h2A;
		foreach (or_cfg[e]) begin
			or_cfg[e].en = 3'h7;
			for (int k = 0; k < 3; k++) or_cfg[e].code[k] = e < 3 ? 8'hC0 + 8'(e * 3 + k) : 8'hE1 + 8'((e - 3) * 3 + k);
		end
		// One direct code on the first stop detector; the second uses two merges
		foreach (stop_cfg[i]) stop_cfg[i] = '{en: 1'b0, code: 8'h00, or_sel: 6'h00, store: 1'b0, chr: 6'h00};
		stop_cfg[0] = '{en: 1'b1, code: 8'hF0, or_sel: 6'h00, store: 1'b1, chr: 6'h3F};
		stop_cfg[1].or_sel = 6'h18;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		rstn = 1'b1;
		@(negedge core_clk);
		chk1(local_ind, 1'b1);
		chk7({remote_ind, tape_fwd, tape_rev, parity_ind, frame_ready}, 7'h01);
		// Panel motions in local
		press(2);
		chk1(tape_rev, 1'b0);
		reel_mode = 1'b1;
		press(2);
		chk1(tape_rev, 1'b1);
		@(negedge core_clk) tape_bot = 1'b1;
		@(negedge core_clk) tape_bot = 1'b0;
		chk1(tape_rev, 1'b0);
		press(3);
		chk1(tape_rev, 1'b1);
		press(5);
		chk1(tape_rev, 1'b0);
		press(3);
		send_frame(8'hF0, 1'b0);
		idle_frame();
		chk1(tape_rev, 1'b0);
		press(4);
		chk1(tape_fwd, 1'b1);
		parity_on = 1'b1;
		send_frame(8'h03, 1'b1);
		idle_frame();
		chk7({tape_fwd, parity_ind}, 7'h01);
		parity_on = 1'b0;
		@(negedge core_clk);
		chk1(parity_ind, 1'b0);
		press(4);
		@(negedge core_clk) tape_eot = 1'b1;
		@(negedge core_clk) tape_eot = 1'b0;
		chk1(tape_fwd, 1'b0);
		$display("Test panel done");
		// Online reading under each of the five switch combinations in modes
		for (int m = 0; m < 5; m++) begin
			{xlat_en, binary_mode, shift_en, parity_on} = modes[m];
			if (!parity_on) lamp_exp = 1'b0;
			slow = m[0];
			saw_full = 1'b0;
			press(1);
			chk7({remote_ind, local_ind}, 7'h02);
			@(negedge core_clk) host_start = 1'b1;
			@(negedge core_clk) host_start = 1'b0;
			chk1(tape_fwd, 1'b1);
			press(5);
			chk1(tape_fwd, 1'b1);
			for (int f = 0; f < 24; f++) begin
				rnd = lfsr(rnd);
				c = rnd[7:0] & 8'hDF;
				model_frame(c, rnd[9] & rnd[3]);
				send_frame(c, rnd[9] & rnd[3]);
			end
			model_frame(shift_code, 1'b0);
			send_frame(shift_code, 1'b0);
			if (xlat_en) begin
				c = m[0] ? 8'hE3 : 8'hF0;
				model_frame(c, 1'b0);
				send_frame(c, 1'b0);
			end
			idle_frame();
			n = 0;
			while ((exp_q.size() != 0 || eor_got != eor_exp) && n < 3000) begin
				@(negedge core_clk);
				n++;
			end
			repeat (4) @(negedge core_clk);
			chk7(7'(exp_q.size()), 7'h00);
			chk7(7'(eor_got), 7'(eor_exp));
			if (xlat_en) chk7({tape_fwd, remote_ind}, 7'h01);
			chk1(parity_ind, lamp_exp);
			if (m == 3) chk1(saw_full, 1'b1);
			press(0);
			chk7({local_ind, remote_ind, tape_fwd}, 7'h04);
			$display("Test mode %0d done", m);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
